// ===== ldrm_pkg.sv
package ldrm_pkg;

    // Bus window and display memory layout (byte addresses)
    localparam logic [15:0] LDRM_RAM_BASE    = 16'h7000;
    localparam logic [15:0] LDRM_RAM_LIMIT   = 16'h7200;
    localparam logic [15:0] LDRM_AREA1_OFS   = 16'h0100;
    localparam int          LDRM_RAM_WORDS   = 128;
    localparam int          LDRM_SEGS        = 56;
    localparam int          LDRM_COMS        = 8;

    // Control register offsets
    localparam logic [15:0] LDRM_CLKCTL_OFS  = 16'h0000;
    localparam logic [15:0] LDRM_CTL_OFS     = 16'h0004;
    localparam logic [15:0] LDRM_DUTY_OFS    = 16'h0008;
    localparam logic [15:0] LDRM_DSP_OFS     = 16'h000c;
    localparam logic [15:0] LDRM_INTF_OFS    = 16'h0010;
    localparam logic [15:0] LDRM_INTE_OFS    = 16'h0014;
    localparam logic [15:0] LDRM_STAT_OFS    = 16'h0018;

    // Field positions
    localparam int          LDRM_DBG_BIT     = 8;
    localparam int          LDRM_DIV_LSB     = 4;
    localparam int          LDRM_SRC_LSB     = 0;
    localparam int          LDRM_EN_BIT      = 0;
    localparam int          LDRM_DUTY_LSB    = 0;
    localparam int          LDRM_SEGN_BIT    = 6;
    localparam int          LDRM_COMN_BIT    = 5;
    localparam int          LDRM_AREA_BIT    = 2;
    localparam int          LDRM_FRAME_BIT   = 0;
    localparam int          LDRM_STAT_COMLSB = 0;
    localparam int          LDRM_STAT_RUN    = 8;

    // Values after reset
    localparam logic        LDRM_DBG_RST     = 1'b1;
    localparam logic [2:0]  LDRM_DIV_RST     = 3'h0;
    localparam logic [1:0]  LDRM_SRC_RST     = 2'h0;
    localparam logic [2:0]  LDRM_DUTY_RST    = 3'h7;
    localparam logic        LDRM_SEGN_RST    = 1'b1;
    localparam logic        LDRM_COMN_RST    = 1'b1;
    localparam logic        LDRM_AREA_RST    = 1'b0;

    // Divider and mapping constants
    localparam logic [2:0]  LDRM_DIV_BYPASS  = 3'h7;
    localparam logic [10:0] LDRM_DIV_BASE    = 11'h010;
    localparam logic [2:0]  LDRM_WIDE_DUTY   = 3'h3;
    localparam int          LDRM_FOLD_WIDE   = 59;
    localparam int          LDRM_FOLD_NARROW = 55;
    localparam int          LDRM_SHARED_SEGS = 4;

endpackage

// ===== ldrm_scan_if.sv
`timescale 1ns/1ps
`default_nettype none

// Configuration down to the scan timer, scan position back up
interface ldrm_scan_if;
    logic       enable;
    logic       run_in_debug;
    logic       debug_halt;
    logic [2:0] divide_sel;
    logic [2:0] duty;
    logic [2:0] com_idx;
    logic       frame_pulse;

    modport ctrl  (output enable, run_in_debug, debug_halt, divide_sel, duty,
                   input  com_idx, frame_pulse);
    modport timer (input  enable, run_in_debug, debug_halt, divide_sel, duty,
                   output com_idx, frame_pulse);
endinterface

`default_nettype wire

// ===== ldrm_scan_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ldrm_scan_timer
    import ldrm_pkg::*;
(
    // Clock and reset
    input  wire logic    core_clk,
    input  wire logic    reset,
    // Configuration and scan position
    ldrm_scan_if.timer   scan
);

    typedef struct packed {
        logic [9:0] div_cnt;
        logic [2:0] com_idx;
        logic       frame;
    } ldrm_timer_t;

    ldrm_timer_t s_q;
    ldrm_timer_t s_d;
    logic [9:0]  limit;
    logic        running;

    // Terminal count of the divider; bypass gives one step per cycle
    always_comb begin
        if (scan.divide_sel == LDRM_DIV_BYPASS) begin
            limit = 10'h000;
        end else begin
            limit = 10'((LDRM_DIV_BASE << scan.divide_sel) - 11'h001);
        end
    end

    // Operating clock is withheld during a debug halt unless told to run
    assign running = scan.enable && (scan.run_in_debug || !scan.debug_halt);

    // Divider, common scan and end-of-frame pulse
    always_comb begin
        s_d = s_q;
        s_d.frame = 1'b0;
        if (!scan.enable) begin
            s_d.div_cnt = 10'h000;
            s_d.com_idx = 3'h0;
        end else if (running) begin
            if (s_q.div_cnt >= limit) begin
                s_d.div_cnt = 10'h000;
                if (s_q.com_idx >= scan.duty) begin
                    s_d.com_idx = 3'h0;
                    s_d.frame = 1'b1;
                end else begin
                    s_d.com_idx = s_q.com_idx + 3'h1;
                end
            end else begin
                s_d.div_cnt = s_q.div_cnt + 10'h001;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign scan.com_idx = s_q.com_idx;
    assign scan.frame_pulse = s_q.frame;

endmodule

`default_nettype wire

// ===== ldrm_top.sv
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - display memory decoded from fixed base address
// - memory mapped by duty and both orderings
// - bit one lights segment, zero darkens
// - display memory readable and writable
// - unused words are plain read/write storage
// - area select chooses area 0 or 1
// - segment ordering ascending or descending by address
// - common ordering ascending or descending by bit
// - only low eight bits stored
// - frame flag set per frame, write-one clears
// - interrupt only when flag and enable set
// - run-in-debug at bit 8, resets one
// - clock stops in debug when run-in-debug zero
// - clock fields locked while module enabled
// - frame event enable gates the interrupt
module ldrm_top
    import ldrm_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // System
    input  wire logic        debug_halt,
    output logic             irq,
    // Panel drive
    output logic [7:0]       common_output,
    output logic [55:0]      segment_output
);

    typedef struct packed {
        logic [LDRM_RAM_WORDS-1:0][7:0] ram;
        logic                           run_in_debug;
        logic [2:0]                     div_sel;
        logic [1:0]                     src_sel;
        logic                           module_enable;
        logic [2:0]                     duty;
        logic                           seg_norm;
        logic                           com_norm;
        logic                           area_sel;
        logic                           frame_flag;
        logic                           frame_enable;
        logic                           waitrequest;
        logic [31:0]                    rdata;
        logic                           irq;
        logic [7:0]                     com_out;
        logic [55:0]                    seg_out;
    } ldrm_state_t;

    localparam ldrm_state_t LDRM_STATE_RST = '{
        ram:           '0,
        run_in_debug:  LDRM_DBG_RST,
        div_sel:       LDRM_DIV_RST,
        src_sel:       LDRM_SRC_RST,
        module_enable: 1'b0,
        duty:          LDRM_DUTY_RST,
        seg_norm:      LDRM_SEGN_RST,
        com_norm:      LDRM_COMN_RST,
        area_sel:      LDRM_AREA_RST,
        frame_flag:    1'b0,
        frame_enable:  1'b0,
        waitrequest:   1'b1,
        rdata:         32'h0000_0000,
        irq:           1'b0,
        com_out:       8'h00,
        seg_out:       56'h0
    };

    ldrm_state_t s_q;
    ldrm_state_t s_d;

    ldrm_scan_if scan ();

    logic        req;
    logic        wr_go;
    logic        rd_go;
    logic        hit_ram;
    logic [15:0] ram_ofs;
    logic [6:0]  ram_idx;
    logic [15:0] reg_ofs;
    logic        lane0;
    logic        lane1;
    logic [31:0] rd_mux;
    logic [2:0]  bit_sel;
    logic        wide;
    logic        frame_clr;
    logic [55:0] seg_next;

    // Scan timer runs the operating clock and the common sequence
    ldrm_scan_timer u_timer (
        .core_clk (core_clk),
        .reset    (reset),
        .scan     (scan.timer)
    );

    // Configuration handed to the timer straight from the registers, debug halt straight from the input pin
    assign scan.enable       = s_q.module_enable;
    assign scan.run_in_debug = s_q.run_in_debug;
    assign scan.debug_halt   = debug_halt;
    assign scan.divide_sel   = s_q.div_sel;
    assign scan.duty         = s_q.duty;

    // Bus phase: first cycle of a request is stalled, the second completes
    assign req   = avs_read || avs_write;
    assign wr_go = avs_write && !s_q.waitrequest;
    assign rd_go = avs_read && s_q.waitrequest;
    assign lane0 = avs_byteenable[0];
    assign lane1 = avs_byteenable[1];

    // Address decode for the display memory window
    assign hit_ram = (avs_address >= LDRM_RAM_BASE) && (avs_address < LDRM_RAM_LIMIT);
    assign ram_ofs = avs_address - LDRM_RAM_BASE;
    // Offset bit 8 picks the area, so area 1 lands 0x100 higher
    assign ram_idx = ram_ofs[8:2];
    assign reg_ofs = {avs_address[15:2], 2'b00};

    // Read data: memory words carry eight bits, the rest read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ram) begin
            rd_mux[7:0] = s_q.ram[ram_idx];
        end else begin
            unique case (reg_ofs)
                LDRM_CLKCTL_OFS: begin
                    rd_mux[LDRM_DBG_BIT] = s_q.run_in_debug;
                    rd_mux[LDRM_DIV_LSB +: 3] = s_q.div_sel;
                    rd_mux[LDRM_SRC_LSB +: 2] = s_q.src_sel;
                end
                LDRM_CTL_OFS: begin
                    rd_mux[LDRM_EN_BIT] = s_q.module_enable;
                end
                LDRM_DUTY_OFS: begin
                    rd_mux[LDRM_DUTY_LSB +: 3] = s_q.duty;
                end
                LDRM_DSP_OFS: begin
                    rd_mux[LDRM_SEGN_BIT] = s_q.seg_norm;
                    rd_mux[LDRM_COMN_BIT] = s_q.com_norm;
                    rd_mux[LDRM_AREA_BIT] = s_q.area_sel;
                end
                LDRM_INTF_OFS: begin
                    rd_mux[LDRM_FRAME_BIT] = s_q.frame_flag;
                end
                LDRM_INTE_OFS: begin
                    rd_mux[LDRM_FRAME_BIT] = s_q.frame_enable;
                end
                LDRM_STAT_OFS: begin
                    rd_mux[LDRM_STAT_COMLSB +: 3] = scan.com_idx;
                    rd_mux[LDRM_STAT_RUN] = s_q.module_enable;
                end
                default: begin
                    rd_mux = 32'h0000_0000;
                end
            endcase
        end
    end

    // Write-one-to-clear request for the frame flag
    assign frame_clr = wr_go && !hit_ram && (reg_ofs == LDRM_INTF_OFS)
                       && lane0 && avs_writedata[LDRM_FRAME_BIT];

    // Wide duties hand SEG0..3 over to commons 4..7
    assign wide = s_q.duty > LDRM_WIDE_DUTY;

    // Memory bit for the active common, inverse ordering counts down from the top
    assign bit_sel = s_q.com_norm ? scan.com_idx : (s_q.duty - scan.com_idx);

    // One slice per segment pin: its word numbers are constants, so only a small mux remains
    for (genvar s = 0; s < LDRM_SEGS; s++) begin : g_seg
        localparam logic [5:0] WORD_NORM   = 6'(s);
        localparam logic [5:0] WORD_WIDE   = 6'(LDRM_FOLD_WIDE - s);
        localparam logic [5:0] WORD_NARROW = 6'(LDRM_FOLD_NARROW - s);
        localparam logic       SHARED      = (s < LDRM_SHARED_SEGS);
        logic [5:0]            word;

        // Word feeding this pin under the current segment ordering
        always_comb begin
            if (s_q.seg_norm) begin
                word = WORD_NORM;
            end else if (wide) begin
                word = WORD_WIDE;
            end else begin
                word = WORD_NARROW;
            end
        end

        // Shared pins act as commons in wide duties; otherwise a one bit lights the segment
        assign seg_next[s] = s_q.module_enable && !(wide && SHARED)
                             && s_q.ram[{s_q.area_sel, word}][bit_sel];
    end

    // Next state: bus handshake, register writes, interrupt and panel drive
    always_comb begin
        s_d = s_q;

        // Stall for one cycle, then release for exactly one cycle
        s_d.waitrequest = !(req && s_q.waitrequest);
        if (rd_go) begin
            s_d.rdata = rd_mux;
        end

        // Display memory write; every word stores, used or not
        if (wr_go && hit_ram && lane0) begin
            s_d.ram[ram_idx] = avs_writedata[7:0];
        end

        // Register writes
        if (wr_go && !hit_ram) begin
            unique case (reg_ofs)
                LDRM_CLKCTL_OFS: begin
                    // Changing the clock under a running divider would glitch the scan
                    if (!s_q.module_enable) begin
                        if (lane1) begin
                            s_d.run_in_debug = avs_writedata[LDRM_DBG_BIT];
                        end
                        if (lane0) begin
                            s_d.div_sel = avs_writedata[LDRM_DIV_LSB +: 3];
                            s_d.src_sel = avs_writedata[LDRM_SRC_LSB +: 2];
                        end
                    end
                end
                LDRM_CTL_OFS: begin
                    if (lane0) begin
                        s_d.module_enable = avs_writedata[LDRM_EN_BIT];
                    end
                end
                LDRM_DUTY_OFS: begin
                    if (lane0) begin
                        s_d.duty = avs_writedata[LDRM_DUTY_LSB +: 3];
                    end
                end
                LDRM_DSP_OFS: begin
                    if (lane0) begin
                        s_d.seg_norm = avs_writedata[LDRM_SEGN_BIT];
                        s_d.com_norm = avs_writedata[LDRM_COMN_BIT];
                        s_d.area_sel = avs_writedata[LDRM_AREA_BIT];
                    end
                end
                LDRM_INTE_OFS: begin
                    if (lane0) begin
                        s_d.frame_enable = avs_writedata[LDRM_FRAME_BIT];
                    end
                end
                default: begin
                    s_d.frame_enable = s_q.frame_enable;
                end
            endcase
        end

        // A frame that ends in the clearing cycle still leaves the flag set
        s_d.frame_flag = (s_q.frame_flag && !frame_clr) || scan.frame_pulse;

        // Interrupt follows the next flag and enable, so it rises with the flag
        s_d.irq = s_d.frame_flag && s_d.frame_enable;

        // Common drive: one-hot on the scanned common while enabled
        s_d.com_out = 8'h00;
        if (s_q.module_enable) begin
            s_d.com_out[scan.com_idx] = 1'b1;
        end

        // Segment drive from the selected area, mapped per duty and orderings
        s_d.seg_out = seg_next;
    end

    // Single state register for the block outside the scan timer, which keeps its own
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_q <= LDRM_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register
    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = s_q.waitrequest;
    assign irq             = s_q.irq;
    assign common_output   = s_q.com_out;
    assign segment_output  = s_q.seg_out;

endmodule

`default_nettype wire

// ===== ldrm_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// Watches bus handshake and panel drive of the display block
module ldrm_top_assertions
    import ldrm_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Bus
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    // Panel
    input  wire logic [7:0]  common_output,
    input  wire logic [55:0] segment_output
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // Bus answers after exactly one wait cycle, ready lasts one cycle
    a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest stuck high");
    a_ready_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("ready longer than one cycle");
    a_ready_needs_req: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("ready without request");
    a_read_data_hold: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
        else $error("read data moved between reads");
    // Only the low byte of a display word has storage
    a_ram_high_zero: assert property (avs_read && !avs_waitrequest && avs_address >= LDRM_RAM_BASE
        && avs_address < LDRM_RAM_LIMIT |-> avs_readdata[31:8] == 24'h000000)
        else $error("display word upper bits not zero");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && ((avs_address > 16'h001b
        && avs_address < LDRM_RAM_BASE) || avs_address >= LDRM_RAM_LIMIT) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    // Commons are scanned one at a time, upward
    a_common_onehot: assert property (common_output != 8'h00 |-> $onehot(common_output))
        else $error("more than one common active");
    a_common_step: assert property (common_output > 8'h01 && $changed(common_output)
        |-> common_output == ($past(common_output) << 1))
        else $error("common scan out of order");
    // No segment lit while no common is scanned
    a_seg_dark_idle: assert property (common_output == 8'h00 |-> segment_output == 56'h0)
        else $error("segments driven while idle");
endmodule

`default_nettype wire

// ===== ldrm_panel_model.sv
`timescale 1ns/1ps
`default_nettype none

// Passive glass: remembers which segments each common lit last
module ldrm_panel_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Panel drive
    input  wire logic [7:0]  common_output,
    input  wire logic [55:0] segment_output,
    // What the glass shows
    output var  logic [55:0] lit [8],
    output var  logic [15:0] frames
);
    logic [7:0] prev_com;

    // A one on a segment while its common is scanned lights the dot
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            frames <= 16'h0000;
            prev_com <= 8'h00;
            for (int c = 0; c < 8; c++) begin
                lit[c] <= 56'h0;
            end
        end else begin
            prev_com <= common_output;
            for (int c = 0; c < 8; c++) begin
                if (common_output == (8'h01 << c)) begin
                    lit[c] <= segment_output;
                end
            end
            // Count only the step onto common 0, so slow dividers do not inflate it
            if (common_output == 8'h01 && prev_com != 8'h01) begin
                frames <= frames + 16'h0001;
            end
        end
    end
endmodule

`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end

module tb;
    import ldrm_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset;
    logic [15:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        debug_halt;
    logic        irq;
    logic [7:0]  common_output;
    logic [55:0] segment_output;
    logic [55:0] lit [8];
    logic [15:0] frames;
    int          n_fail = 0;
    int          n_checks = 0;

    ldrm_top DUT (.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .debug_halt(debug_halt),
        .irq(irq), .common_output(common_output), .segment_output(segment_output));
    ldrm_panel_model panel (.core_clk(core_clk), .reset(reset), .common_output(common_output),
        .segment_output(segment_output), .lit(lit), .frames(frames));

    // 250 MHz core clock
    always #2 core_clk = ~core_clk;

    // One bus transfer, held until ready is seen at a rising edge
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // Ready and read data are taken at the rising edge that completes the transfer
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask

    // Let the scan run a few frames, then stop it
    task automatic run_frames();
        logic [15:0] f;
        f = frames;
        wr(LDRM_CTL_OFS, 32'h1);
        repeat (300) begin
            @(posedge core_clk);
            if (frames > f + 16'h0004) break;
        end
        wr(LDRM_CTL_OFS, 32'h0);
    endtask

    task automatic t_reset();
        rd(LDRM_CLKCTL_OFS, 32'h100);
        rd(LDRM_CTL_OFS, 32'h0);
        rd(LDRM_DUTY_OFS, 32'h7);
        rd(LDRM_DSP_OFS, 32'h60);
        rd(LDRM_INTF_OFS, 32'h0);
        rd(LDRM_INTE_OFS, 32'h0);
        rd(16'h0100, 32'h0);
        $display("reset values test done");
    endtask

    task automatic t_ram();
        wr(16'h7000, 32'hffffffff);
        rd(16'h7000, 32'h000000ff);
        wr(16'h71fc, 32'h000000a5);
        rd(16'h71fc, 32'h000000a5);
        wr(16'h7200, 32'h00000001);
        rd(16'h7200, 32'h0);
        $display("display memory test done");
    endtask

    // Word 0 = bit0, word 1 = bit1, area 1 word 0 = both; walk the orderings
    task automatic t_map();
        logic [2:0]  dt [5] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h7};
        logic [7:0]  ds [5] = '{8'h60, 8'h40, 8'h20, 8'h64, 8'h60};
        logic [55:0] e0 [5] = '{56'h1, 56'h2, 56'h80000000000000, 56'h1, 56'h10};
        logic [55:0] e1 [5] = '{56'h2, 56'h1, 56'h40000000000000, 56'h1, 56'h0};
        wr(LDRM_CLKCTL_OFS, 32'h170);
        wr(16'h7000, 32'h01);
        wr(16'h7004, 32'h02);
        wr(16'h7100, 32'h03);
        for (int i = 0; i < 5; i++) begin
            if (i == 4) wr(16'h7010, 32'h01);
            wr(LDRM_DUTY_OFS, {29'h0, dt[i]});
            wr(LDRM_DSP_OFS, {24'h0, ds[i]});
            run_frames();
            `CHK(lit[0], e0[i])
            `CHK(lit[1], e1[i])
        end
        $display("mapping test done");
    endtask

    // Flag was set by the frames above; enable is still zero
    task automatic t_irq();
        rd(LDRM_INTF_OFS, 32'h1);
        `CHK(irq, 1'b0)
        wr(LDRM_INTE_OFS, 32'h1);
        repeat (2) @(negedge core_clk);
        `CHK(irq, 1'b1)
        wr(LDRM_INTF_OFS, 32'h1);
        repeat (2) @(negedge core_clk);
        `CHK(irq, 1'b0)
        rd(LDRM_INTF_OFS, 32'h0);
        wr(LDRM_INTE_OFS, 32'h0);
        $display("interrupt test done");
    endtask

    task automatic t_clk();
        logic [7:0] c;
        wr(LDRM_CTL_OFS, 32'h1);
        wr(LDRM_CLKCTL_OFS, 32'h0);
        rd(LDRM_CLKCTL_OFS, 32'h170);
        wr(LDRM_CTL_OFS, 32'h0);
        wr(LDRM_CLKCTL_OFS, 32'h070);
        rd(LDRM_CLKCTL_OFS, 32'h070);
        wr(LDRM_CTL_OFS, 32'h1);
        debug_halt <= 1'b1;
        repeat (4) @(negedge core_clk);
        c = common_output;
        repeat (20) @(negedge core_clk);
        `CHK(common_output, c)
        rd(LDRM_STAT_OFS, 32'h100);
        debug_halt <= 1'b0;
        repeat (4) @(negedge core_clk);
        `CHK(common_output == c, 1'b0)
        wr(LDRM_CTL_OFS, 32'h0);
        $display("debug clock test done");
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        conclude();
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        avs_address = 16'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        debug_halt = 1'b0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_ram();
        t_map();
        t_irq();
        t_clk();
        conclude();
    end
endmodule

bind ldrm_top ldrm_top_assertions u_chk (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .common_output(common_output), .segment_output(segment_output));

`default_nettype wire
